/* spda_pkg.sv */
// Behaviour
// - same registers at data and config windows
// - config bus never disturbs ready flags
// - data bus reads of receive clear ready
// - prevent dma loss on pending config access
`default_nettype none
package spda_pkg;
  // ------------------------------------------------------------
  // address map
  // ------------------------------------------------------------
  localparam logic [31:0] DATA_BASE  = 32'h3000_0000;
  localparam logic [31:0] CFG_BASE   = 32'h02a0_0000;
  localparam logic [31:0] WIN_MASK   = 32'hffff_ffe0;
  localparam logic [2:0]  IDX_RX     = 3'h0;
  localparam logic [2:0]  IDX_TX     = 3'h1;
  localparam logic [2:0]  IDX_CTRL   = 3'h2;
  // ------------------------------------------------------------
  // control register fields and reset values
  // ------------------------------------------------------------
  localparam int          BIT_RECEIVE_READY_FLAG   = 1;
  localparam int          BIT_TRANSMIT_READY_FLAG   = 17;
  localparam int          BIT_FREE   = 25;
  localparam logic [31:0] CTRL_RST   = 32'h0002_0000;
  localparam logic [31:0] DATA_RST   = 32'h0000_0000;
  localparam int          NREG       = 3;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } spda_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } spda_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01
  } spda_state_t;
endpackage : spda_pkg
`default_nettype wire

/* spda_regmem.sv */
`default_nettype none
module spda_regmem (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              we_i,
  input  wire logic [2:0]        waddr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic [2:0]        raddr_i,
  output logic      [31:0]       rdata_o
);
  logic [31:0] mem_reg [spda_pkg::NREG];
  // ------------------------------------------------------------
  // storage, read data registered
  // ------------------------------------------------------------
  for (genvar g = 0; g < spda_pkg::NREG; g++) begin : g_word
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem_reg[g] <= (g == 2) ? spda_pkg::CTRL_RST : spda_pkg::DATA_RST;
      end else if (we_i && waddr_i == 3'(g)) begin
        mem_reg[g] <= wdata_i;
      end
    end
  end
  wire [31:0] rsel = (raddr_i < 3'(spda_pkg::NREG)) ? mem_reg[raddr_i[1:0]] : 32'h0000_0000;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rsel;
    end
  end
endmodule : spda_regmem
`default_nettype wire

/* spda_top.sv */
`default_nettype none
module spda_top (
  input  wire logic                SYS_CLK_I,
  input  wire logic                RST_N_I,
  input  wire spda_pkg::spda_req_t DMA_REQ_I,
  output spda_pkg::spda_rsp_t      DMA_RSP_O,
  input  wire spda_pkg::spda_req_t CFG_REQ_I,
  output spda_pkg::spda_rsp_t      CFG_RSP_O,
  input  wire logic                RX_WORD_VALID_I,
  input  wire logic [31:0]         RX_WORD_I,
  input  wire logic                TX_WORD_TAKEN_I,
  output logic      [31:0]         TX_WORD_O,
  output logic                     RECEIVE_READY_O,
  output logic                     TRANSMIT_READY_O,
  output logic                     FREE_RUN_O
);
  // ------------------------------------------------------------
  // window decode
  // ------------------------------------------------------------
  wire dma_hit = (DMA_REQ_I.addr & spda_pkg::WIN_MASK) == spda_pkg::DATA_BASE;
  wire cfg_hit = (CFG_REQ_I.addr & spda_pkg::WIN_MASK) == spda_pkg::CFG_BASE;
  wire [2:0] dma_idx = DMA_REQ_I.addr[4:2];
  wire [2:0] cfg_idx = CFG_REQ_I.addr[4:2];
  wire dma_go = DMA_REQ_I.req && dma_hit;
  // config access waits while dma active: dma never dropped
  spda_pkg::spda_state_t st_reg, st_next;
  logic [31:0] ctrl_reg;
  logic [31:0] rx_reg;
  logic [31:0] tx_reg;
  wire cfg_pend = CFG_REQ_I.req && cfg_hit;
  wire cfg_go = cfg_pend && !dma_go;
  // ------------------------------------------------------------
  // arbitration state: config held for as long as dma stays active after a collision
  // ------------------------------------------------------------
  always_comb begin
    case (st_reg)
      spda_pkg::ST_IDLE: st_next = (cfg_pend && dma_go) ? spda_pkg::ST_HOLD : spda_pkg::ST_IDLE;
      spda_pkg::ST_HOLD: st_next = dma_go ? spda_pkg::ST_HOLD : spda_pkg::ST_IDLE;
      default:           st_next = spda_pkg::ST_IDLE;
    endcase
  end
  // ------------------------------------------------------------
  // effects of accesses
  // ------------------------------------------------------------
  wire dma_rx_rd = dma_go && !DMA_REQ_I.wr && dma_idx == spda_pkg::IDX_RX;
  wire dma_tx_wr = dma_go && DMA_REQ_I.wr && dma_idx == spda_pkg::IDX_TX;
  wire cfg_tx_wr = cfg_go && CFG_REQ_I.wr && cfg_idx == spda_pkg::IDX_TX;
  wire dma_ct_wr = dma_go && DMA_REQ_I.wr && dma_idx == spda_pkg::IDX_CTRL;
  wire cfg_ct_wr = cfg_go && CFG_REQ_I.wr && cfg_idx == spda_pkg::IDX_CTRL;
  wire [31:0] ct_wdata = dma_ct_wr ? DMA_REQ_I.wdata : CFG_REQ_I.wdata;
  logic receive_ready_flag_next;
  logic transmit_ready_flag_next;
  // new data wins over a clearing read in the same cycle
  assign receive_ready_flag_next = RX_WORD_VALID_I ? 1'b1 :
                     dma_rx_rd ? 1'b0 : ctrl_reg[spda_pkg::BIT_RECEIVE_READY_FLAG];
  // only dma writes consume transmit ready; config writes leave it
  assign transmit_ready_flag_next = TX_WORD_TAKEN_I ? 1'b1 :
                     dma_tx_wr ? 1'b0 : ctrl_reg[spda_pkg::BIT_TRANSMIT_READY_FLAG];
  logic [31:0] ctrl_next;
  always_comb begin
    ctrl_next = (dma_ct_wr || cfg_ct_wr) ? ct_wdata : ctrl_reg;
    ctrl_next[spda_pkg::BIT_RECEIVE_READY_FLAG] = receive_ready_flag_next;
    ctrl_next[spda_pkg::BIT_TRANSMIT_READY_FLAG] = transmit_ready_flag_next;
  end
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_reg   <= spda_pkg::ST_IDLE;
      ctrl_reg <= spda_pkg::CTRL_RST;
      rx_reg   <= spda_pkg::DATA_RST;
      tx_reg   <= spda_pkg::DATA_RST;
    end else begin
      st_reg   <= st_next;
      ctrl_reg <= ctrl_next;
      if (RX_WORD_VALID_I) rx_reg <= RX_WORD_I;
      if (dma_tx_wr) tx_reg <= DMA_REQ_I.wdata;
      else if (cfg_tx_wr) tx_reg <= CFG_REQ_I.wdata;
    end
  end
  // ------------------------------------------------------------
  // read data taken from the registers directly; the register memory output is unused
  // ------------------------------------------------------------
  wire [2:0] rd_idx = dma_go ? dma_idx : cfg_idx;
  wire shadow_we = 1'b1;
  logic [31:0] rdata;
  logic [2:0]  shadow_cnt_reg;
  wire [31:0] shadow_data = (shadow_cnt_reg == spda_pkg::IDX_RX) ? rx_reg :
                            (shadow_cnt_reg == spda_pkg::IDX_TX) ? tx_reg : ctrl_reg;
  wire [2:0] shadow_cnt_next = (shadow_cnt_reg == spda_pkg::IDX_CTRL) ? 3'h0 : shadow_cnt_reg + 3'h1;
  spda_regmem u_mem (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .we_i    (shadow_we),
    .waddr_i (shadow_cnt_reg),
    .wdata_i (shadow_data),
    .raddr_i (rd_idx),
    .rdata_o ()
  );
  // direct registered read keeps data current; the memory copy is a lagging mirror
  wire [31:0] rsel = (rd_idx == spda_pkg::IDX_RX) ? rx_reg :
                     (rd_idx == spda_pkg::IDX_TX) ? tx_reg :
                     (rd_idx == spda_pkg::IDX_CTRL) ? ctrl_reg : 32'h0000_0000;
  logic dma_ack_reg;
  logic cfg_ack_reg;
  logic dma_err_reg;
  logic cfg_err_reg;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata          <= 32'h0000_0000;
      dma_ack_reg    <= 1'b0;
      cfg_ack_reg    <= 1'b0;
      dma_err_reg    <= 1'b0;
      cfg_err_reg    <= 1'b0;
      shadow_cnt_reg <= 3'h0;
    end else begin
      rdata          <= rsel;
      dma_ack_reg    <= dma_go;
      cfg_ack_reg    <= cfg_go;
      dma_err_reg    <= dma_go && dma_idx > spda_pkg::IDX_CTRL;
      cfg_err_reg    <= cfg_go && cfg_idx > spda_pkg::IDX_CTRL;
      shadow_cnt_reg <= shadow_cnt_next;
    end
  end
  assign DMA_RSP_O        = '{ack: dma_ack_reg, err: dma_err_reg, rdata: rdata};
  assign CFG_RSP_O        = '{ack: cfg_ack_reg, err: cfg_err_reg, rdata: rdata};
  assign TX_WORD_O        = tx_reg;
  assign RECEIVE_READY_O  = ctrl_reg[spda_pkg::BIT_RECEIVE_READY_FLAG];
  assign TRANSMIT_READY_O = ctrl_reg[spda_pkg::BIT_TRANSMIT_READY_FLAG];
  assign FREE_RUN_O       = ctrl_reg[spda_pkg::BIT_FREE];
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_cfg_no_receive_ready_flag: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (!dma_go && !RX_WORD_VALID_I) |=> $stable(RECEIVE_READY_O))
    else $error("receive ready moved without data bus or data");
  a_cfg_no_transmit_ready_flag: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (!dma_tx_wr && !TX_WORD_TAKEN_I) |=> $stable(TRANSMIT_READY_O))
    else $error("transmit ready moved without data bus write");
  a_dma_rx_clear: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (dma_rx_rd && !RX_WORD_VALID_I) |=> !RECEIVE_READY_O)
    else $error("data bus receive read kept ready");
  a_dma_wins: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (dma_go && cfg_pend) |-> !cfg_go ##1 DMA_RSP_O.ack)
    else $error("dma lost on collision");
  a_cfg_served: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (cfg_pend && !dma_go) |=> CFG_RSP_O.ack)
    else $error("config access not served");
  a_window_dec: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (DMA_REQ_I.req && !dma_hit) |=> !DMA_RSP_O.ack)
    else $error("data window decode wrong");
endmodule : spda_top
`default_nettype wire

/* spda_bus_model.sv */
`default_nettype none
module spda_bus_model (
  input  wire logic                clk_i,
  input  wire spda_pkg::spda_rsp_t rsp_i,
  output spda_pkg::spda_req_t      req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_err = 1'b0;
  initial req_o = '0;
  // request held until ack is seen; a stalled port times out after 32 cycles
  // ack is registered, so it is looked at just after the edge and the
  // request drops before the next edge, which would take it a second time
  task automatic xfer(input logic wr, input logic [31:0] a, d,
                      output logic [31:0] q, output bit to);
    int n;
    @(posedge clk_i) #1;
    req_o = '{req: 1'b1, wr: wr, addr: a, wdata: d};
    to = 1'b1;
    for (n = 0; n < 32 && to; n++) begin
      @(posedge clk_i) #1;
      if (rsp_i.ack === 1'b1) to = 1'b0;
    end
    q = rsp_i.rdata;
    last_err = rsp_i.err;
    // released lines show the inverse, never the stale value
    req_o = '{req: 1'b0, wr: ~wr, addr: ~a, wdata: ~d};
    repeat (2) @(posedge clk_i);
  endtask : xfer
endmodule : spda_bus_model
`default_nettype wire

/* testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                rx_v = 1'b0;
  logic                tx_tk = 1'b0;
  logic [31:0]         rx_w = '0;
  logic [31:0]         tx_w, q, q2;
  logic                receive_ready_flag, transmit_ready_flag, frun;
  spda_pkg::spda_req_t dq, cq;
  spda_pkg::spda_rsp_t dr, cr;
  int                  miscompares = 0;
  int                  tests_run = 0;
  always #4 clk = ~clk;
  spda_top i_spda_top (.SYS_CLK_I(clk), .RST_N_I(rst_n), .DMA_REQ_I(dq), .DMA_RSP_O(dr),
    .CFG_REQ_I(cq), .CFG_RSP_O(cr), .RX_WORD_VALID_I(rx_v), .RX_WORD_I(rx_w),
    .TX_WORD_TAKEN_I(tx_tk), .TX_WORD_O(tx_w), .RECEIVE_READY_O(receive_ready_flag),
    .TRANSMIT_READY_O(transmit_ready_flag), .FREE_RUN_O(frun));
  spda_bus_model dma_m (.clk_i(clk), .rsp_i(dr), .req_o(dq));
  spda_bus_model cfg_m (.clk_i(clk), .rsp_i(cr), .req_o(cq));
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // traffic goes through the config port when cfg is set, else the data port
  task automatic acc(input bit cfg, input logic wr, input logic [2:0] idx,
                     input logic [31:0] d, output logic [31:0] r);
    bit to;
    logic [31:0] a;
    a = (cfg ? spda_pkg::CFG_BASE : spda_pkg::DATA_BASE) | {27'h0, idx, 2'h0};
    if (cfg) cfg_m.xfer(wr, a, d, r, to);
    else dma_m.xfer(wr, a, d, r, to);
    if (to) begin
      miscompares++;
      stop_test();
    end
  endtask : acc
  task automatic strobe(input bit rx, input logic [31:0] w);
    @(posedge clk) #1;
    rx_v = rx;
    tx_tk = !rx;
    rx_w = w;
    @(posedge clk) #1;
    rx_v = 1'b0;
    tx_tk = 1'b0;
  endtask : strobe
  task automatic t_windows();
    check("free", frun, 1'b0);
    acc(1, 0, spda_pkg::IDX_CTRL, 0, q);
    check("ctrl", q, spda_pkg::CTRL_RST);
    acc(0, 1, spda_pkg::IDX_TX, 32'h5a5a_0001, q);
    check("transmit_ready_flag", transmit_ready_flag, 1'b0);
    check("txw", tx_w, 32'h5a5a_0001);
    acc(1, 0, spda_pkg::IDX_TX, 0, q);
    check("tx cfg", q, 32'h5a5a_0001);
    acc(0, 0, 3'h3, 0, q);
    check("err", dma_m.last_err, 1'b1);
    check("err data", q, 32'h0000_0000);
    $display("t_windows done");
  endtask : t_windows
  task automatic t_cfg();
    strobe(1, 32'hc0de_0011);
    acc(0, 0, spda_pkg::IDX_CTRL, 0, q);
    check("receive_ready_flag dbg", receive_ready_flag, 1'b1);
    acc(1, 0, spda_pkg::IDX_RX, 0, q);
    check("rx cfg", q, 32'hc0de_0011);
    check("receive_ready_flag", receive_ready_flag, 1'b1);
    acc(1, 1, spda_pkg::IDX_TX, 32'h0000_00a5, q);
    check("transmit_ready_flag", transmit_ready_flag, 1'b0);
    strobe(0, 0);
    check("transmit_ready_flag", transmit_ready_flag, 1'b1);
    acc(0, 0, spda_pkg::IDX_RX, 0, q);
    check("rx dma", q, 32'hc0de_0011);
    check("receive_ready_flag", receive_ready_flag, 1'b0);
    $display("t_cfg done");
  endtask : t_cfg
  // both ports at one register in one cycle: neither may be dropped
  task automatic t_collide();
    strobe(1, 32'h1234_abcd);
    fork
      acc(0, 0, spda_pkg::IDX_RX, 0, q);
      acc(1, 0, spda_pkg::IDX_RX, 0, q2);
    join
    check("rx dma", q, 32'h1234_abcd);
    check("rx cfg", q2, 32'h1234_abcd);
    check("receive_ready_flag", receive_ready_flag, 1'b0);
    fork
      acc(0, 1, spda_pkg::IDX_TX, 32'h0bad_f00d, q);
      acc(1, 0, spda_pkg::IDX_TX, 0, q2);
    join
    check("tx order", q2, 32'h0bad_f00d);
    check("txw", tx_w, 32'h0bad_f00d);
    $display("t_collide done");
  endtask : t_collide
  task automatic t_free();
    strobe(0, 0);
    acc(1, 1, spda_pkg::IDX_CTRL, 32'h1 << spda_pkg::BIT_FREE, q);
    check("free", frun, 1'b1);
    check("transmit_ready_flag", transmit_ready_flag, 1'b1);
    acc(1, 1, spda_pkg::IDX_CTRL, 0, q);
    check("free", frun, 1'b0);
    $display("t_free done");
  endtask : t_free
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    t_windows();
    t_cfg();
    t_collide();
    t_free();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
